// file: logic/fpc_top.sv
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// [RQ1] Fan drive output is active high; high powers the fan.
// [RQ2] During a fan fault the drive output stays fully on.
// [RQ3] Fault and drive never latch; fan recovery returns to normal PWM.
// [RQ4] Fixed-frequency pulse train, duty adjustable from 0% to 100%.
// [RQ5] Duty command is the larger of temperature and minimum-speed levels.
// [RQ6] PWM comes from comparing the duty command with a sawtooth ramp.
// [RQ7] Duty maps linearly: low ramp limit 0%, high limit 100%.
// [RQ8] Power-up or shutdown release forces drive high for 32 periods.
// [RQ9] A sense pulse during start-up leads to normal PWM afterwards.
// [RQ10] No pulse: second start-up; still none: fault output pulled low.
// [RQ11] Minimum-speed level shares the temperature range and floors duty.
// [RQ12] 32 periods without pulse: 3-period full-on check, then start-up.
// [RQ13] At least 16 pulses in 32 periods clears the fault.
// [RQ14] Shutdown holds drive low, fault inactive; release runs start-up.
// [RQ15] Sense pulses arrive as single-cycle strobes and are counted.
// [RQ16] Levels are digital codes; ramp is a free-running counter.
module fpc_top #(
  parameter int LEVEL_W = 8 // Width of level codes and ramp.
) (
  input  wire logic          aclk,          // Clock, 10 MHz.
  input  wire logic          aresetn,       // Sync reset, active low.
  input  wire fpc_pkg::fpc_addr_t s_axi_awaddr,  // Write address.
  input  wire logic          s_axi_awvalid, // Write address valid.
  output logic               s_axi_awready, // Write address ready.
  input  wire fpc_pkg::fpc_word_t s_axi_wdata,   // Write data.
  input  wire fpc_pkg::fpc_strb_t s_axi_wstrb,   // Write byte strobes.
  input  wire logic          s_axi_wvalid,  // Write data valid.
  output logic               s_axi_wready,  // Write data ready.
  output fpc_pkg::fpc_resp_t s_axi_bresp,   // Write response.
  output logic               s_axi_bvalid,  // Write response valid.
  input  wire logic          s_axi_bready,  // Write response ready.
  input  wire fpc_pkg::fpc_addr_t s_axi_araddr,  // Read address.
  input  wire logic          s_axi_arvalid, // Read address valid.
  output logic               s_axi_arready, // Read address ready.
  output fpc_pkg::fpc_word_t s_axi_rdata,   // Read data.
  output fpc_pkg::fpc_resp_t s_axi_rresp,   // Read response.
  output logic               s_axi_rvalid,  // Read data valid.
  input  wire logic          s_axi_rready,  // Read data ready.
  input  wire logic          sense_stb,     // One-cycle fan pulse.
  output logic               fan_drive_out, // Fan drive, high is on.
  output logic               fault_o,       // Fault pin level, always 0.
  output logic               fault_oe,      // Pull fault pin low.
  input  wire logic          fault_i,       // Fault pin as seen.
  output logic               irq            // Level interrupt.
);
  import fpc_pkg::*;

  if (LEVEL_W < 2 || LEVEL_W > 16) begin : g_bad_width
    $error("LEVEL_W must lie between 2 and 16.");
  end

  fpc_core_if #(.W(LEVEL_W)) core ();

  fpc_ramp #(.W(LEVEL_W)) u_ramp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .core    (core.ramp_mp)
  );

  fpc_tach u_tach (
    .aclk    (aclk),
    .aresetn (aresetn),
    .core    (core.tach_mp)
  );

  // Software-visible registers.
  logic               shdn_ff,   nxt_shdn;
  logic [LEVEL_W-1:0] temp_ff,   nxt_temp;
  logic [LEVEL_W-1:0] min_ff,    nxt_min;
  logic [IRQ_W-1:0]   istat_ff,  nxt_istat;
  logic [IRQ_W-1:0]   imask_ff,  nxt_imask;
  logic               irq_ff,    nxt_irq;
  logic [IRQ_W-1:0]   ev;
  logic [IRQ_W-1:0]   w1c;
  // Bus channel state.
  logic               awfull_ff, nxt_awfull;
  logic               wfull_ff,  nxt_wfull;
  fpc_addr_t          awaddr_ff, nxt_awaddr;
  fpc_word_t          wdata_ff,  nxt_wdata;
  fpc_strb_t          wstrb_ff,  nxt_wstrb;
  logic               bvalid_ff, nxt_bvalid;
  fpc_resp_t          bresp_ff,  nxt_bresp;
  logic               rvalid_ff, nxt_rvalid;
  fpc_word_t          rdata_ff,  nxt_rdata;
  fpc_resp_t          rresp_ff,  nxt_rresp;
  fpc_word_t          merged;
  logic               do_write;
  // Fan control state.
  fpc_state_t         state_ff,  nxt_state;
  logic [5:0]         pcnt_ff,   nxt_pcnt;
  logic               drive_ff,  nxt_drive;
  logic               fault_ff,  nxt_fault;

  // True for every mapped register address.
  function automatic logic addr_hit(input fpc_addr_t a);
    return (a == ADDR_CTRL) || (a == ADDR_TEMP) || (a == ADDR_MIN) ||
           (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT) ||
           (a == ADDR_IRQ_MASK);
  endfunction

  // Read view of a register; unused bits read as zero.
  function automatic fpc_word_t reg_word(input fpc_addr_t a);
    fpc_word_t w;
    w = '0;
    case (a)
      ADDR_CTRL:     w[CTRL_SHDN_BIT] = shdn_ff;
      ADDR_TEMP:     w[LEVEL_W-1:0] = temp_ff;
      ADDR_MIN:      w[LEVEL_W-1:0] = min_ff;
      ADDR_STATUS: begin
        w[STAT_STATE_LSB +: $bits(fpc_state_t)] = state_ff;
        w[STAT_DRIVE_BIT] = drive_ff;
        w[STAT_FAULT_BIT] = fault_ff;
        w[STAT_PIN_BIT]   = fault_i;
        w[STAT_SEEN_BIT]  = core.seen;
      end
      ADDR_IRQ_STAT: w[IRQ_W-1:0] = istat_ff;
      ADDR_IRQ_MASK: w[IRQ_W-1:0] = imask_ff;
      default:       w = '0;
    endcase
    return w;
  endfunction

  // Byte-lane merge of write data over the current contents.
  function automatic fpc_word_t wr_merge(input fpc_word_t old_w,
                                         input fpc_word_t new_w,
                                         input fpc_strb_t strb);
    fpc_word_t r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Address and data are held apart until both have arrived.
  assign s_axi_awready = !awfull_ff && !bvalid_ff;
  assign s_axi_wready  = !wfull_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign do_write      = awfull_ff && wfull_ff && !bvalid_ff;

  // A process rather than an assign, so that a change in any register that
  // the read view shows re-evaluates the merge, not only its arguments.
  always_comb begin
    merged = wr_merge(reg_word(awaddr_ff), wdata_ff, wstrb_ff);
  end

  // Write channels, register updates and interrupt status.
  always_comb begin
    nxt_awfull = awfull_ff;
    nxt_wfull  = wfull_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_shdn   = shdn_ff;
    nxt_temp   = temp_ff;
    nxt_min    = min_ff;
    nxt_imask  = imask_ff;
    w1c        = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_awfull = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_wfull = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_awfull = 1'b0;
      nxt_wfull  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = addr_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      case (awaddr_ff)
        ADDR_CTRL:     nxt_shdn  = merged[CTRL_SHDN_BIT];
        ADDR_TEMP:     nxt_temp  = merged[LEVEL_W-1:0];
        ADDR_MIN:      nxt_min   = merged[LEVEL_W-1:0]; // RQ11
        ADDR_IRQ_STAT: w1c = wdata_ff[IRQ_W-1:0] & {IRQ_W{wstrb_ff[0]}};
        ADDR_IRQ_MASK: nxt_imask = merged[IRQ_W-1:0];
        default:       nxt_shdn  = shdn_ff;
      endcase
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    // A new event outranks a clear arriving in the same cycle.
    nxt_istat = (istat_ff & ~w1c) | ev;
    nxt_irq   = |(nxt_istat & nxt_imask);
  end

  // Read channel: one cycle from address to data.
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = reg_word(s_axi_araddr);
      nxt_rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awfull_ff <= 1'b0;
      wfull_ff  <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
      shdn_ff   <= 1'b0;
      temp_ff   <= '0;
      min_ff    <= '0;
      istat_ff  <= '0;
      imask_ff  <= '0;
      irq_ff    <= 1'b0;
    end else begin
      awfull_ff <= nxt_awfull;
      wfull_ff  <= nxt_wfull;
      awaddr_ff <= nxt_awaddr;
      wdata_ff  <= nxt_wdata;
      wstrb_ff  <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
      shdn_ff   <= nxt_shdn;
      temp_ff   <= nxt_temp;
      min_ff    <= nxt_min;
      istat_ff  <= nxt_istat;
      imask_ff  <= nxt_imask;
      irq_ff    <= nxt_irq;
    end
  end

  // The higher level wins, so minimum speed is a floor on the duty.
  assign core.duty = (temp_ff > min_ff) ? temp_ff : min_ff; // RQ5
  assign core.stb  = sense_stb; // RQ15

  // Fan state machine; every timer advances on the ramp wrap tick.
  always_comb begin
    nxt_state = state_ff;
    nxt_pcnt  = pcnt_ff;
    core.clr  = 1'b0;
    ev        = '0;
    if (shdn_ff) begin
      nxt_state = ST_SHUT; // RQ14
      nxt_pcnt  = '0;
      core.clr  = 1'b1;
    end else begin
      case (state_ff)
        ST_SHUT: begin
          nxt_state = ST_START1; // RQ14
          core.clr  = 1'b1;
        end
        ST_START1, ST_START2: begin
          if (core.tick && pcnt_ff == STARTUP_PERIODS - PERIOD_STEP) begin
            nxt_pcnt = '0;
            core.clr = 1'b1;
            if (core.seen) begin
              nxt_state = ST_RUN; // RQ9
            end else if (state_ff == ST_START1) begin
              nxt_state = ST_START2; // RQ10
            end else begin
              nxt_state = ST_FAULT; // RQ10
              ev[IRQ_FAULT_SET] = 1'b1;
            end
          end else if (core.tick) begin
            nxt_pcnt = pcnt_ff + PERIOD_STEP; // RQ8
          end
        end
        ST_RUN: begin
          if (core.tick) begin
            core.clr = 1'b1;
            if (core.seen) begin
              nxt_pcnt = '0; // RQ12
            end else if (pcnt_ff == MISS_PERIODS - PERIOD_STEP) begin
              nxt_pcnt  = '0;
              nxt_state = ST_DIAG; // RQ12
              ev[IRQ_DIAG] = 1'b1;
            end else begin
              nxt_pcnt = pcnt_ff + PERIOD_STEP;
            end
          end
        end
        ST_DIAG: begin
          if (core.tick && core.seen) begin
            nxt_pcnt  = '0;
            nxt_state = ST_RUN;
            core.clr  = 1'b1;
          end else if (core.tick &&
                       pcnt_ff == DIAG_PERIODS - PERIOD_STEP) begin
            // A failed check gets one last start-up period.
            nxt_pcnt  = '0;
            nxt_state = ST_START2; // RQ12
            core.clr  = 1'b1;
          end else if (core.tick) begin
            nxt_pcnt = pcnt_ff + PERIOD_STEP;
          end
        end
        ST_FAULT: begin
          if (core.tick && pcnt_ff == RECOVER_WINDOW - PERIOD_STEP) begin
            nxt_pcnt = '0;
            core.clr = 1'b1;
            if (core.enough) begin
              nxt_state = ST_RUN; // RQ13
              ev[IRQ_FAULT_CLR] = 1'b1;
            end
          end else if (core.tick) begin
            nxt_pcnt = pcnt_ff + PERIOD_STEP;
          end
        end
        default: begin
          nxt_state = ST_SHUT;
          nxt_pcnt  = '0;
        end
      endcase
    end
    // Outputs track the next state so they align with state_ff.
    case (nxt_state)
      ST_SHUT: nxt_drive = 1'b0; // RQ14
      ST_RUN:  nxt_drive = core.pwm_raw; // RQ6
      default: nxt_drive = 1'b1; // RQ2
    endcase
    nxt_fault = (nxt_state == ST_FAULT); // RQ3
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_START1;
      pcnt_ff  <= '0;
      drive_ff <= 1'b1;
      fault_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pcnt_ff  <= nxt_pcnt;
      drive_ff <= nxt_drive;
      fault_ff <= nxt_fault;
    end
  end

  assign fan_drive_out = drive_ff; // RQ1
  assign fault_o       = 1'b0;
  assign fault_oe      = fault_ff;
  assign irq           = irq_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  a_shut_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    (state_ff == ST_SHUT) |-> (!fan_drive_out && !fault_oe))
    else $error("Shutdown left drive or fault active.");
  a_shdn_enter: assert property (@(posedge aclk) disable iff (!aresetn) // RQ14
    shdn_ff |=> (state_ff == ST_SHUT))
    else $error("Shutdown request was not obeyed.");
  a_fault_full_on: assert property (@(posedge aclk) // RQ2
    disable iff (!aresetn)
    (state_ff == ST_FAULT) |-> (fan_drive_out && fault_oe))
    else $error("Fault state without full drive and fault pin.");
  a_start_full_on: assert property (@(posedge aclk) // RQ8
    disable iff (!aresetn)
    (state_ff inside {ST_START1, ST_START2, ST_DIAG}) |-> fan_drive_out)
    else $error("Start-up or check period without full drive.");
  a_run_pwm_tie: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
    (state_ff == ST_RUN) |-> (fan_drive_out == $past(core.pwm_raw)))
    else $error("Run drive does not follow the ramp compare.");
  a_duty_floor: assert property (@(posedge aclk) disable iff (!aresetn) // RQ5
    (state_ff == ST_RUN && $past(core.ramp) < $past(min_ff))
    |-> fan_drive_out)
    else $error("Drive fell below the minimum-speed floor.");
  a_start_retry: assert property (@(posedge aclk) // RQ10
    disable iff (!aresetn)
    (state_ff == ST_START1 && core.tick && !core.seen && !shdn_ff &&
     pcnt_ff == STARTUP_PERIODS - PERIOD_STEP)
    |=> (state_ff == ST_START2))
    else $error("Failed first start-up did not retry.");
  a_start_fail: assert property (@(posedge aclk) disable iff (!aresetn) // RQ10
    (state_ff == ST_START2 && core.tick && !core.seen && !shdn_ff &&
     pcnt_ff == STARTUP_PERIODS - PERIOD_STEP)
    |=> (fault_oe ##1 fault_oe))
    else $error("Second failed start-up did not raise the fault.");
  a_start_pass: assert property (@(posedge aclk) disable iff (!aresetn) // RQ9
    (state_ff inside {ST_START1, ST_START2} && core.tick && core.seen &&
     !shdn_ff && pcnt_ff == STARTUP_PERIODS - PERIOD_STEP)
    |=> (state_ff == ST_RUN))
    else $error("Start-up with pulses did not enter normal PWM.");
  a_miss_diag: assert property (@(posedge aclk) disable iff (!aresetn) // RQ12
    (state_ff == ST_RUN && core.tick && !core.seen && !shdn_ff &&
     pcnt_ff == MISS_PERIODS - PERIOD_STEP)
    |=> (state_ff == ST_DIAG))
    else $error("Missing pulses did not start the check period.");
  a_fault_exit: assert property (@(posedge aclk) disable iff (!aresetn) // RQ13
    (state_ff == ST_FAULT && core.tick && core.enough && !shdn_ff &&
     pcnt_ff == RECOVER_WINDOW - PERIOD_STEP)
    |=> (state_ff == ST_RUN && !fault_oe))
    else $error("Recovered fan did not release the fault.");
endmodule

// file: pkg/fpc_pkg.sv
package fpc_pkg;

  // Register byte addresses on the AXI4-Lite slave.
  typedef logic [7:0]  fpc_addr_t;
  typedef logic [31:0] fpc_word_t;
  typedef logic [3:0]  fpc_strb_t;
  typedef logic [1:0]  fpc_resp_t;

  localparam fpc_addr_t ADDR_CTRL     = 8'h00;
  localparam fpc_addr_t ADDR_TEMP     = 8'h04;
  localparam fpc_addr_t ADDR_MIN      = 8'h08;
  localparam fpc_addr_t ADDR_STATUS   = 8'h0C;
  localparam fpc_addr_t ADDR_IRQ_STAT = 8'h10;
  localparam fpc_addr_t ADDR_IRQ_MASK = 8'h14;

  localparam fpc_resp_t RESP_OKAY   = 2'h0;
  localparam fpc_resp_t RESP_SLVERR = 2'h2;

  // Field positions.
  localparam int CTRL_SHDN_BIT  = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DRIVE_BIT = 3;
  localparam int STAT_FAULT_BIT = 4;
  localparam int STAT_PIN_BIT   = 5;
  localparam int STAT_SEEN_BIT  = 6;

  // Interrupt event bits.
  localparam int IRQ_W         = 3;
  localparam int IRQ_FAULT_SET = 0;
  localparam int IRQ_FAULT_CLR = 1;
  localparam int IRQ_DIAG      = 2;

  // Timers, counted in PWM periods, and the recovery threshold, counted in sense pulses.
  localparam logic [5:0] STARTUP_PERIODS = 6'h20;
  localparam logic [5:0] MISS_PERIODS    = 6'h20;
  localparam logic [5:0] DIAG_PERIODS    = 6'h03;
  localparam logic [5:0] RECOVER_WINDOW  = 6'h20;
  localparam logic [5:0] PERIOD_STEP     = 6'h01;
  localparam logic [4:0] RECOVER_PULSES  = 5'h10;
  localparam logic [4:0] PULSE_STEP      = 5'h01;

  typedef enum logic [2:0] {
    ST_SHUT   = 3'h0,
    ST_START1 = 3'h1,
    ST_START2 = 3'h2,
    ST_RUN    = 3'h3,
    ST_DIAG   = 3'h4,
    ST_FAULT  = 3'h5
  } fpc_state_t;

endpackage

// file: pkg/fpc_core_if.sv
`timescale 1ns/1ps
interface fpc_core_if #(
  parameter int W = 8
);
  logic [W-1:0] ramp;
  logic [W-1:0] duty;
  logic         tick;
  logic         pwm_raw;
  logic         stb;
  logic         clr;
  logic         seen;
  logic         enough;

  modport ramp_mp (input duty, output ramp, tick, pwm_raw);
  modport tach_mp (input stb, clr, output seen, enough);
  modport core_mp (input ramp, tick, pwm_raw, seen, enough,
                   output duty, stb, clr);
endinterface

// file: logic/fpc_ramp.sv
`timescale 1ns/1ps
module fpc_ramp #(
  parameter int W = 8 // Ramp and duty width.
) (
  input wire logic aclk,    // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  fpc_core_if.ramp_mp core  // Ramp, tick and comparator.
);
  import fpc_pkg::*;

  logic [W-1:0] ramp_ff;
  logic [W-1:0] nxt_ramp;

  // The ramp wraps from all ones to zero once per PWM period.
  always_comb begin
    nxt_ramp = ramp_ff + {{(W-1){1'b0}}, 1'b1}; // RQ16
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_ff <= '0;
    end else begin
      ramp_ff <= nxt_ramp;
    end
  end

  // Full-scale code must give a solid high, so it bypasses the compare.
  assign core.ramp    = ramp_ff;
  assign core.tick    = (ramp_ff == '1);
  assign core.pwm_raw = (core.duty == '1) || (ramp_ff < core.duty); // RQ7

  a_ramp_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // RQ6
    core.tick |=> (ramp_ff == '0))
    else $error("Ramp did not wrap after its top.");
  a_zero_duty: assert property (@(posedge aclk) disable iff (!aresetn) // RQ4
    (core.duty == '0) |-> !core.pwm_raw)
    else $error("Zero duty gave a high pulse.");
endmodule

// file: logic/fpc_tach.sv
`timescale 1ns/1ps
module fpc_tach (
  input wire logic aclk,    // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  fpc_core_if.tach_mp core  // Strobe in, pulse summary out.
);
  import fpc_pkg::*;

  logic       seen_ff;
  logic       nxt_seen;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;

  // A strobe in the clear cycle was already used by the decision,
  // so the clear wins here to avoid counting it in two windows.
  always_comb begin
    nxt_seen = seen_ff | core.stb; // RQ15
    nxt_cnt  = cnt_ff;
    if (core.stb && (cnt_ff != RECOVER_PULSES)) begin
      nxt_cnt = cnt_ff + PULSE_STEP;
    end
    if (core.clr) begin
      nxt_seen = 1'b0;
      nxt_cnt  = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_ff <= 1'b0;
      cnt_ff  <= '0;
    end else begin
      seen_ff <= nxt_seen;
      cnt_ff  <= nxt_cnt;
    end
  end

  assign core.seen   = seen_ff | core.stb;
  assign core.enough = (cnt_ff == RECOVER_PULSES) ||
                       (core.stb && (cnt_ff == RECOVER_PULSES - PULSE_STEP));

  a_seen_sticky: assert property (@(posedge aclk) // RQ15
    disable iff (!aresetn)
    (core.stb && !core.clr) |=> core.seen)
    else $error("Sense strobe was not held as seen.");
endmodule

// file: testbench/fpc_fan_model.sv
`timescale 1ns/1ps
// Fan and sense front end: strobes every 8 cycles while spinning.
module fpc_fan_model (
  input  wire logic aclk,      // Clock.
  input  wire logic spin,      // Fan turns when high.
  input  wire logic fault_oe,  // Device pulls fault pin low.
  output logic      sense_stb, // One-cycle pulse per current pulse.
  output logic      fault_i    // Fault pin level.
);
  logic [2:0] ph_ff = 3'h0;

  // A stalled fan gives no strobe at all, so the line stays low.
  always_ff @(posedge aclk) begin
    ph_ff     <= ph_ff + 3'h1;
    sense_stb <= spin && (ph_ff == 3'h0);
  end

  // The pin has a pull-up, so a released pin reads high.
  assign fault_i = !fault_oe;
endmodule

// file: testbench/tb_fan_pwm_startup_fault_control.sv
`timescale 1ns/1ps
module tb_fan_pwm_startup_fault_control;
  import fpc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, spin = 1'b0;
  fpc_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  fpc_word_t s_axi_wdata = 32'h0, s_axi_rdata;
  fpc_strb_t s_axi_wstrb = 4'hF;
  fpc_resp_t s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sense_stb, fan_drive_out, fault_o, fault_oe;
  logic fault_i, irq;
  fpc_word_t rdv;
  int mismatches = 0, check_count = 0, cycles = 0, n;

  // Short level codes give 16-cycle periods and a quick run.
  fpc_top #(.LEVEL_W(4)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sense_stb, .fan_drive_out, .fault_o, .fault_oe, .fault_i, .irq);
  fpc_fan_model fan (.aclk, .spin, .fault_oe, .sense_stb, .fault_i);

  always #50 aclk = ~aclk;

  // Whole run needs about 3000 cycles; the ceiling leaves ample margin.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Address and data go out together; each drops once taken.
  task automatic wr(fpc_addr_t a, fpc_word_t d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) done = 1'b1;
    end
    // The response code is taken at the edge that sees bvalid high.
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(fpc_addr_t a, output fpc_word_t d, output fpc_resp_t r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) done = 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Poll the state field until it shows the wanted state.
  task automatic wait_state(fpc_state_t s);
    do rd(ADDR_STATUS, rdv, rsp); while (rdv[2:0] !== s);
  endtask

  // Any 16 consecutive cycles hold exactly one period's on time.
  task automatic duty(output int hi);
    hi = 0;
    repeat (16) begin
      @(posedge aclk);
      if (fan_drive_out === 1'b1) hi++;
    end
  endtask

  task automatic t_startup();
    spin <= 1'b1;
    repeat (480) @(posedge aclk);
    rd(ADDR_STATUS, rdv, rsp);
    chk("startup state", ST_START1, rdv[2:0]);
    chk("startup drive", 1, fan_drive_out);
    wait_state(ST_RUN);
    rd(8'h1C, rdv, rsp);
    chk("unmapped resp", RESP_SLVERR, rsp);
    chk("unmapped data", 0, rdv);
    wr(8'h1C, 32'h0);
    chk("unmapped wr resp", RESP_SLVERR, rsp);
    // Lane 0 disabled: the level code must keep its reset value.
    s_axi_wstrb <= 4'hE;
    wr(ADDR_TEMP, 32'hF);
    chk("write resp", RESP_OKAY, rsp);
    s_axi_wstrb <= 4'hF;
    rd(ADDR_TEMP, rdv, rsp);
    chk("masked lane", 0, rdv);
  endtask

  task automatic t_duty();
    int tab[5][3] = '{'{0,0,0}, '{8,0,8}, '{3,12,12}, '{15,0,16},
                      '{10,5,10}};
    foreach (tab[i]) begin
      wr(ADDR_TEMP, tab[i][0]);
      wr(ADDR_MIN, tab[i][1]);
      repeat (20) @(posedge aclk);
      duty(n);
      chk("on cycles", tab[i][2], n);
    end
  endtask

  task automatic t_fault();
    wr(ADDR_TEMP, 0);
    wr(ADDR_MIN, 0);
    wr(ADDR_IRQ_MASK, 7);
    spin <= 1'b0;
    wait_state(ST_DIAG);
    chk("check drive", 1, fan_drive_out);
    wait_state(ST_START2);
    wait_state(ST_FAULT);
    chk("fault pin", 1, fault_oe);
    chk("status pin", 0, rdv[STAT_PIN_BIT]);
    chk("status fault", 1, rdv[STAT_FAULT_BIT]);
    chk("status drive", 1, rdv[STAT_DRIVE_BIT]);
    chk("pin level", 0, fault_o);
    duty(n);
    chk("fault drive", 16, n);
    chk("irq raised", 1, irq);
    rd(ADDR_IRQ_STAT, rdv, rsp);
    chk("irq events", 5, rdv);
    wr(ADDR_IRQ_STAT, 5);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 0, irq);
  endtask

  task automatic t_recover();
    spin <= 1'b1;
    wait_state(ST_RUN);
    chk("fault released", 0, fault_oe);
    chk("pin released", 1, rdv[STAT_PIN_BIT]);
    duty(n);
    chk("pwm resumed", 0, n);
    rd(ADDR_IRQ_STAT, rdv, rsp);
    chk("clear event", 2, rdv);
  endtask

  task automatic t_shut();
    wr(ADDR_CTRL, 1);
    repeat (2) @(posedge aclk);
    chk("shut drive", 0, fan_drive_out);
    chk("shut fault", 0, fault_oe);
    // A stalled fan on release makes the first start-up fail.
    spin <= 1'b0;
    wr(ADDR_CTRL, 0);
    rd(ADDR_STATUS, rdv, rsp);
    chk("restart state", ST_START1, rdv[2:0]);
    chk("restart drive", 1, fan_drive_out);
    wait_state(ST_START2);
    chk("retry drive", 1, fan_drive_out);
    chk("retry no fault", 0, fault_oe);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_startup();
    t_duty();
    t_fault();
    t_recover();
    t_shut();
    summarize();
  end
endmodule
